// file: hdl/spo_pkg.sv
// Purpose: constants for the pipelined sample output port
// Assumes: one system clock, sample strobe arrives as an asynchronous pin
// Notes:   codes are offset binary, 10 bits wide
// Functional notes
// [R1] strobe rising edge freezes and starts conversion
// [R2] flag low in span, high outside
// [R3] one corrected 10-bit parallel word per sample
// [R4] output word updates on strobe rising edge
// [R5] word appears five strobe periods after capture
// [R6] offset binary; saturate all ones or zeros
// [R7] bit nine is msb, bit zero lsb
// [R8] out of range holds max or min code
// [R9] capture logic registers word five edges later
package spo_pkg;
  localparam int unsigned WORD_W     = 10;
  localparam int unsigned PIPE_DEPTH = 5;
  localparam int unsigned FINE_W     = 5;
  localparam logic [WORD_W-1:0] CODE_MAX = 10'h3_FF;
  localparam logic [WORD_W-1:0] CODE_MIN = 10'h0_00;
  localparam logic [WORD_W-1:0] CODE_RST = 10'h0_00;
endpackage : spo_pkg

// file: hdl/spo_stage_if.sv
`timescale 1ns/1ns
// Purpose: carries one pipeline stage's word and flag
// Assumes: same clock on both ends
// Notes:   src drives, dst reads
interface spo_stage_if #(parameter int unsigned W = 10);
  logic [W-1:0] word;
  logic         flag;
  modport src (output word, output flag);
  modport dst (input word, input flag);
endinterface : spo_stage_if

// file: hdl/spo_convert.sv
`timescale 1ns/1ns
// Purpose: corrects coarse/fine results into one saturated word
// Assumes: inputs are held samples, combinational only
// Notes:   coarse/fine overlap by one bit for error correction
module spo_convert
  import spo_pkg::*;
(
  input  wire logic [FINE_W-1:0] coarse_i,
  input  wire logic [FINE_W:0]   fine_i,
  input  wire logic              over_i,
  input  wire logic              under_i,
  spo_stage_if.src               res
);
  logic [WORD_W:0] sum;
  // coarse weight plus fine with its redundant bit; carry means overflow
  // below-span beats a carry, so an under sample reads full scale only when over is also set
  always_comb begin
    sum = {1'b0, coarse_i, {FINE_W{1'b0}}} + {{(WORD_W-FINE_W){1'b0}}, fine_i}; // R3
    if (over_i) begin
      res.word = CODE_MAX; // R6 R8
      res.flag = 1'b1;     // R2
    end else if (under_i) begin
      res.word = CODE_MIN; // R6 R8
      res.flag = 1'b1;     // R2
    end else if (sum[WORD_W]) begin
      // a carry past the top code is still above span: clamp, never wrap
      res.word = CODE_MAX; // R6 R8
      res.flag = 1'b1;     // R2
    end else begin
      res.word = sum[WORD_W-1:0]; // R7
      res.flag = 1'b0;            // R2
    end
  end
endmodule // spo_convert

// file: hdl/spo_top.sv
`timescale 1ns/1ns
// Purpose: digital output side of a sampling converter
// Assumes: strobe pin asynchronous; analog results arrive as digital inputs
// Notes:   latency is five strobe periods, counted in strobe edges
//          strobe high and low must each last two clocks or an edge is lost
//          no analog here: over, under, coarse and fine stand in for it
module spo_top
  import spo_pkg::*;
#(
  parameter int unsigned DEPTH = PIPE_DEPTH
)(
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  input  wire logic              strobe_i,
  input  wire logic [FINE_W-1:0] coarse_i,
  input  wire logic [FINE_W:0]   fine_i,
  input  wire logic              over_i,
  input  wire logic              under_i,
  output logic [WORD_W-1:0]      sample_word_o,
  output logic                   over_range_o
);
  //////////////////////////////////////////////////////////////////////
  // strobe and analog inputs pass two flops before any logic; the
  // analog stand-ins settle long before the strobe rises, so a plain
  // double flop per bit is enough for them, with no handshake
  // limitation: a stand-in that moves near the strobe may be torn
  logic [2:0]        strb_q;
  logic [2:0]        strb_d;
  logic [FINE_W-1:0] co_m_q;
  logic [FINE_W-1:0] co_m_d;
  logic [FINE_W-1:0] co_q;
  logic [FINE_W-1:0] co_d;
  logic [FINE_W:0]   fi_m_q;
  logic [FINE_W:0]   fi_m_d;
  logic [FINE_W:0]   fi_q;
  logic [FINE_W:0]   fi_d;
  logic [1:0]        ov_m_q;
  logic [1:0]        ov_m_d;
  logic [1:0]        ov_q;
  logic [1:0]        ov_d;
  logic              edge_w;
  // next values of the synchroniser chains
  always_comb begin
    strb_d = {strb_q[1:0], strobe_i};
    co_m_d = coarse_i;
    co_d   = co_m_q;
    fi_m_d = fine_i;
    fi_d   = fi_m_q;
    ov_m_d = {over_i, under_i};
    ov_d   = ov_m_q;
  end
  // register only; reset clears the strobe chain so no false edge follows
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      strb_q <= 3'h0;
      co_m_q <= '0;
      co_q   <= '0;
      fi_m_q <= '0;
      fi_q   <= '0;
      ov_m_q <= 2'h0;
      ov_q   <= 2'h0;
    end else begin
      strb_q <= strb_d;
      co_m_q <= co_m_d;
      co_q   <= co_d;
      fi_m_q <= fi_m_d;
      fi_q   <= fi_d;
      ov_m_q <= ov_m_d;
      ov_q   <= ov_d;
    end
  end
  // edge detect reads only the second and third flops
  assign edge_w = strb_q[1] & ~strb_q[2]; // R1 R4

  //////////////////////////////////////////////////////////////////////
  // hold the sample at the strobe edge, then correct it
  logic [FINE_W-1:0] hco_q, hco_d;
  logic [FINE_W:0]   hfi_q, hfi_d;
  logic [1:0]        hov_q, hov_d;
  spo_stage_if #(.W(WORD_W)) conv ();
  // next held sample: take the synchronised inputs on the detected edge,
  // otherwise keep them, so the corrector sees one frozen value per period
  always_comb begin
    hco_d = hco_q;
    hfi_d = hfi_q;
    hov_d = hov_q;
    if (edge_w) begin
      hco_d = co_q; // R1
      hfi_d = fi_q;
      hov_d = ov_q;
    end
  end
  // register only
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      hco_q <= '0;
      hfi_q <= '0;
      hov_q <= 2'h0;
    end else begin
      hco_q <= hco_d;
      hfi_q <= hfi_d;
      hov_q <= hov_d;
    end
  end
  // corrector is combinational; its result is read only at the next edge
  spo_convert u_conv (
    .coarse_i (hco_q),
    .fine_i   (hfi_q),
    .over_i   (hov_q[1]),
    .under_i  (hov_q[0]),
    .res      (conv.src)
  );

  //////////////////////////////////////////////////////////////////////
  // pipeline advances once per strobe edge; the held sample enters
  // stage 1 one edge after capture, so the output is DEPTH edges late
  logic [WORD_W-1:0] pw_q [DEPTH-1];
  logic [WORD_W-1:0] pw_d [DEPTH-1];
  logic              pf_q [DEPTH-1];
  logic              pf_d [DEPTH-1];
  logic [WORD_W-1:0] out_d;
  logic              or_d;
  // next stage contents; DEPTH-1 inner stages plus the output register
  // give DEPTH strobe periods of latency, and nothing moves between
  // edges, so capture logic may sample anywhere clear of the update at the third clock after the strobe rise
  always_comb begin
    for (int i = 0; i < DEPTH-1; i++) begin
      pw_d[i] = pw_q[i];
      pf_d[i] = pf_q[i];
    end
    out_d = sample_word_o;
    or_d  = over_range_o;
    if (edge_w) begin
      pw_d[0] = conv.word; // R5
      pf_d[0] = conv.flag;
      for (int i = 1; i < DEPTH-1; i++) begin
        pw_d[i] = pw_q[i-1];
        pf_d[i] = pf_q[i-1];
      end
      out_d = pw_q[DEPTH-2]; // R4 R5
      or_d  = pf_q[DEPTH-2]; // R2
    end
  end
  // register only; the output flops drive the pins directly
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH-1; i++) begin
        pw_q[i] <= CODE_RST;
        pf_q[i] <= 1'b0;
      end
      sample_word_o <= CODE_RST;
      over_range_o  <= 1'b0;
    end else begin
      for (int i = 0; i < DEPTH-1; i++) begin
        pw_q[i] <= pw_d[i];
        pf_q[i] <= pf_d[i];
      end
      sample_word_o <= out_d;
      over_range_o  <= or_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // assertions; they watch the held sample, the corrector and each stage,
  // so a fault shows at the stage that made it, not five periods later
  // at the pins; the sum helper is the plain coarse/fine weighting
  function automatic logic [WORD_W:0] span_sum(
    input logic [FINE_W-1:0] c,
    input logic [FINE_W:0]   f
  );
    span_sum = ((WORD_W+1)'(c) << FINE_W) + (WORD_W+1)'(f);
  endfunction

  a_reset_clears: assert property (@(posedge clk_sys_i) // R4
    rst_i |=> sample_word_o == CODE_RST && !over_range_o) else $error("reset did not clear");
  a_edge_one_cycle: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R1
    edge_w |=> !edge_w) else $error("strobe edge seen twice");
  a_hold_steady: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R1
    !edge_w |=> $stable(hco_q) && $stable(hfi_q) && $stable(hov_q))
    else $error("held sample moved between edges");
  a_out_stable_between: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R4
    !edge_w |=> $stable(sample_word_o)) else $error("word changed without strobe edge");
  a_flag_stable_between: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R2
    !edge_w |=> $stable(over_range_o)) else $error("flag changed without strobe edge");
  a_flag_saturates_word: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R8
    conv.flag |-> (conv.word == CODE_MAX || conv.word == CODE_MIN))
    else $error("out of range word not saturated");
  a_pins_saturate: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R8
    over_range_o |-> (sample_word_o == CODE_MAX || sample_word_o == CODE_MIN))
    else $error("flagged word at pins not saturated");
  a_over_gives_max: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R6
    hov_q[1] |-> conv.word == CODE_MAX && conv.flag) else $error("over not all ones");
  a_under_gives_min: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R6
    hov_q == 2'b01 |-> conv.word == CODE_MIN && conv.flag)
    else $error("under not all zeros");
  a_in_span_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R2
    (hov_q == 2'b00 && span_sum(hco_q, hfi_q) <= {1'b0, CODE_MAX})
      |-> !conv.flag && {1'b0, conv.word} == span_sum(hco_q, hfi_q))
    else $error("in span word wrong");
  a_carry_saturates: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R8
    (hov_q == 2'b00 && span_sum(hco_q, hfi_q) > {1'b0, CODE_MAX})
      |-> conv.flag && conv.word == CODE_MAX)
    else $error("carry not saturated");
  a_hold_on_edge: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R1
    edge_w |=> hco_q == $past(co_q)) else $error("sample not frozen on edge");
  a_stage_in: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R3
    edge_w |=> pw_q[0] == $past(conv.word) && pf_q[0] == $past(conv.flag))
    else $error("corrected word not taken");
  // every inner stage after the first takes its neighbour's word on a strobe edge only
  for (genvar g = 1; g < DEPTH-1; g++) begin : g_stage_chk
    a_stage_shift: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R5
      edge_w |=> pw_q[g] == $past(pw_q[g-1]) && pf_q[g] == $past(pf_q[g-1]))
      else $error("stage did not shift");
  end
  // and no stage moves between strobe edges
  for (genvar g = 0; g < DEPTH-1; g++) begin : g_stage_keep
    a_stage_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R5
      !edge_w |=> $stable(pw_q[g]) && $stable(pf_q[g]))
      else $error("stage moved without strobe edge");
  end
  a_stage_to_out: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R5
    edge_w |=> sample_word_o == $past(pw_q[DEPTH-2])) else $error("pipeline skip");
  a_flag_follows: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R2
    edge_w |=> over_range_o == $past(pf_q[DEPTH-2])) else $error("flag not aligned");
endmodule // spo_top

// file: bench/spo_capture_model.sv
`timescale 1ns/1ns
// Purpose: far-side capture logic for the sample words
// Assumes: strobe stays high long enough for the output update to land
// Notes:   samples on the strobe fall to stay clear of the update edge
module spo_capture_model
  import spo_pkg::*;
(
  input  wire logic              strobe_i,
  input  wire logic [WORD_W-1:0] word_i,
  input  wire logic              flag_i,
  output logic      [WORD_W-1:0] cap_word_o,
  output logic                   cap_flag_o
);
  // take word and flag together, one capture per strobe period
  always_ff @(negedge strobe_i) begin
    cap_word_o <= word_i;
    cap_flag_o <= flag_i;
  end
endmodule // spo_capture_model

// file: bench/spo_bench.sv
`timescale 1ns/1ns
// Purpose: self-checking bench for the sample output port
// Assumes: strobe period of 11 clk, 6 low then 5 high
// Notes:   each capture is judged against the sample five strobes back
module pipelined_sample_output_port_bench;
  import spo_pkg::*;
  logic              clk_sys_i, rst_i, strobe_i, over_i, under_i, cap_flag, over_range_o;
  logic [FINE_W-1:0] coarse_i;
  logic [FINE_W:0]   fine_i;
  logic [WORD_W-1:0] sample_word_o, cap_word;
  logic [WORD_W:0]   exp_q[$];
  int                n_errors = 0, check_count = 0, cycles = 0;
  spo_top u_spo_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .strobe_i(strobe_i),
    .coarse_i(coarse_i), .fine_i(fine_i), .over_i(over_i), .under_i(under_i),
    .sample_word_o(sample_word_o), .over_range_o(over_range_o));
  spo_capture_model u_spo_capture_model (.strobe_i(strobe_i), .word_i(sample_word_o),
    .flag_i(over_range_o), .cap_word_o(cap_word), .cap_flag_o(cap_flag));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // hang guard; the whole run needs well under 1000 cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (n_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one strobe period; inputs move in the low phase so the sync flops see them settled
  task automatic send(input logic [4:0] c, input logic [5:0] f, input logic o, u);
    logic [10:0]     s;
    logic [WORD_W:0] e;
    s = 11'(c) * 11'h0_20 + 11'(f);
    if (o) e = {1'b1, CODE_MAX};
    else if (u) e = {1'b1, CODE_MIN};
    else if (s > 11'h3_FF) e = {1'b1, CODE_MAX};
    else e = {1'b0, s[9:0]};
    exp_q.push_back(e);
    @(posedge clk_sys_i);
    #1 {coarse_i, fine_i, over_i, under_i} = {c, f, o, u};
    repeat (5) @(posedge clk_sys_i);
    #1 strobe_i = 1'b1;
    // the word must still stand from the last update until this rise
    if (check_count > 0) begin
      check_count++;
      if ({over_range_o, sample_word_o} !== {cap_flag, cap_word}) begin
        n_errors++;
        $display("MISMATCH held_word expected %h seen %h", {cap_flag, cap_word},
          {over_range_o, sample_word_o});
      end
    end
    repeat (5) @(posedge clk_sys_i);
    #1 strobe_i = 1'b0;
    #1 check_count++;
    e = (exp_q.size() > 5) ? exp_q[exp_q.size()-6] : {1'b0, CODE_RST};
    if ({cap_flag, cap_word} !== e) begin
      n_errors++;
      $display("MISMATCH capture expected %h seen %h", e, {cap_flag, cap_word});
    end
  endtask
  // a sample followed by five fillers, so its word is judged before returning
  task automatic run1(input logic [4:0] c, input logic [5:0] f, input logic o, u);
    send(c, f, o, u);
    repeat (5) send(5'h0_0, 6'h0_0, 1'b0, 1'b0);
  endtask
  task automatic t_in_span();
    run1(5'h1_0, 6'h0_0, 1'b0, 1'b0);
    run1(5'h0_A, 6'h1_5, 1'b0, 1'b0);
  endtask
  task automatic t_midscale();
    run1(5'h0_F, 6'h1_F, 1'b0, 1'b0);
  endtask
  task automatic t_out_of_span();
    run1(5'h0_3, 6'h0_1, 1'b1, 1'b0);
    run1(5'h1_C, 6'h0_1, 1'b0, 1'b1);
    run1(5'h0_3, 6'h0_1, 1'b1, 1'b1);
    run1(5'h1_F, 6'h2_0, 1'b0, 1'b0);
    run1(5'h1_F, 6'h3_F, 1'b0, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_i, strobe_i, coarse_i, fine_i, over_i, under_i} = '0;
    rst_i = 1'b1;
    repeat (8) @(posedge clk_sys_i);
    #1 rst_i = 1'b0;
    t_in_span();
    t_midscale();
    t_out_of_span();
    print_verdict();
  end
endmodule // pipelined_sample_output_port_bench
